// ---- hw/axup_if.sv ----
// five-channel axi3 link between master end and slave end
`timescale 1ns/1ps
interface axup_if;
  import axup_pkg::*;
  logic [ID_W-1:0] awid;
  logic [ADDR_W-1:0] awaddr;
  logic [LEN_W-1:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic [1:0] awlock;
  logic [3:0] awcache;
  logic [2:0] awprot;
  logic awvalid;
  logic awready;
  logic [ID_W-1:0] wid;
  logic [DATA_W-1:0] wdata;
  logic [STRB_W-1:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [ID_W-1:0] bid;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [ID_W-1:0] arid;
  logic [ADDR_W-1:0] araddr;
  logic [LEN_W-1:0] arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic [1:0] arlock;
  logic [3:0] arcache;
  logic [2:0] arprot;
  logic arvalid;
  logic arready;
  logic [ID_W-1:0] rid;
  logic [DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;
  modport master (
    output awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
    input awready,
    output wid, wdata, wstrb, wlast, wvalid,
    input wready,
    input bid, bresp, bvalid,
    output bready,
    output arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
    input arready,
    input rid, rdata, rresp, rlast, rvalid,
    output rready
  );
  modport slave (
    input awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awvalid,
    output awready,
    input wid, wdata, wstrb, wlast, wvalid,
    output wready,
    output bid, bresp, bvalid,
    input bready,
    input arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arvalid,
    output arready,
    output rid, rdata, rresp, rlast, rvalid,
    input rready
  );
endinterface : axup_if

// ---- hw/axup_master.sv ----
// axi3 master end: single outstanding write or read burst from a user command
`timescale 1ns/1ps
module axup_master
  import axup_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  axup_if.master bus,
  input wire logic I_WR_REQ,
  input wire logic I_RD_REQ,
  input wire logic [ID_W-1:0] I_ID,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [LEN_W-1:0] I_LEN,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic [STRB_W-1:0] I_WSTRB,
  output logic O_BUSY,
  output logic O_WDATA_TAKE,
  output logic O_RDATA_VALID,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_DONE,
  output logic [1:0] O_RESP
);
  typedef enum logic [2:0] {M_IDLE, M_AW, M_W, M_B, M_AR, M_R} axup_mst_type;
  axup_mst_type st_q;
  logic [LEN_W-1:0] cnt_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      st_q <= M_IDLE;
      bus.awvalid <= 1'b0;
      bus.wvalid <= 1'b0;
      bus.bready <= 1'b0;
      bus.arvalid <= 1'b0;
      bus.rready <= 1'b0;
      bus.awid <= '0;
      bus.awaddr <= '0;
      bus.awlen <= '0;
      bus.awsize <= '0;
      bus.awburst <= BURST_INCR;
      bus.arid <= '0;
      bus.araddr <= '0;
      bus.arlen <= '0;
      bus.arsize <= '0;
      bus.arburst <= BURST_INCR;
      bus.wid <= '0;
      bus.wdata <= '0;
      bus.wstrb <= '0;
      bus.wlast <= 1'b0;
      cnt_q <= '0;
      O_BUSY <= 1'b0;
      O_WDATA_TAKE <= 1'b0;
      O_RDATA_VALID <= 1'b0;
      O_RDATA <= '0;
      O_DONE <= 1'b0;
      O_RESP <= RESP_OKAY;
    end else begin
      O_WDATA_TAKE <= 1'b0;
      O_RDATA_VALID <= 1'b0;
      O_DONE <= 1'b0;
      unique case (st_q)
        M_IDLE: begin
          if (I_WR_REQ) begin
            bus.awvalid <= 1'b1;
            bus.awid <= I_ID;
            bus.awaddr <= I_ADDR;
            bus.awlen <= I_LEN;
            bus.awsize <= 3'b010;
            cnt_q <= I_LEN;
            O_BUSY <= 1'b1;
            st_q <= M_AW;
          end else if (I_RD_REQ) begin
            bus.arvalid <= 1'b1;
            bus.arid <= I_ID;
            bus.araddr <= I_ADDR;
            bus.arlen <= I_LEN;
            bus.arsize <= 3'b010;
            O_BUSY <= 1'b1;
            st_q <= M_AR;
          end
        end
        M_AW: begin
          if (bus.awready) begin
            bus.awvalid <= 1'b0;
            bus.wvalid <= 1'b1;
            bus.wid <= bus.awid;
            bus.wdata <= I_WDATA;
            bus.wstrb <= I_WSTRB;
            bus.wlast <= (cnt_q == '0);
            O_WDATA_TAKE <= 1'b1;
            st_q <= M_W;
          end
        end
        M_W: begin
          if (bus.wready) begin
            if (bus.wlast) begin
              bus.wvalid <= 1'b0;
              bus.wlast <= 1'b0;
              bus.bready <= 1'b1;
              st_q <= M_B;
            end else begin
              bus.wdata <= I_WDATA;
              bus.wstrb <= I_WSTRB;
              bus.wlast <= (cnt_q == 4'h1);
              cnt_q <= cnt_q - 1'b1;
              O_WDATA_TAKE <= 1'b1;
            end
          end
        end
        M_B: begin
          if (bus.bvalid) begin
            bus.bready <= 1'b0;
            O_DONE <= 1'b1;
            // a mismatched response id is flagged as a slave error
            O_RESP <= (bus.bid == bus.awid) ? bus.bresp : RESP_SLVERR;
            O_BUSY <= 1'b0;
            st_q <= M_IDLE;
          end
        end
        M_AR: begin
          if (bus.arready) begin
            bus.arvalid <= 1'b0;
            bus.rready <= 1'b1;
            st_q <= M_R;
          end
        end
        M_R: begin
          if (bus.rvalid) begin
            O_RDATA_VALID <= 1'b1;
            O_RDATA <= bus.rdata;
            if (bus.rlast) begin
              bus.rready <= 1'b0;
              O_DONE <= 1'b1;
              O_RESP <= bus.rresp;
              O_BUSY <= 1'b0;
              st_q <= M_IDLE;
            end
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // fixed attributes: plain unprivileged, non-cacheable, normal access
  assign bus.awprot = M_PROT;
  assign bus.awcache = M_CACHE;
  assign bus.awlock = M_LOCK;
  assign bus.arprot = M_PROT;
  assign bus.arcache = M_CACHE;
  assign bus.arlock = M_LOCK;
endmodule : axup_master

// ---- hw/axup_pkg.sv ----
// shared constants for the axi3 user port ends
package axup_pkg;
  localparam int ID_W = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int LEN_W = 4;
  localparam logic [1:0] BURST_INCR = 2'b01;
  localparam logic [2:0] SIZE_MAX = 3'b011;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_EXOKAY = 2'b01;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam logic [2:0] M_PROT = 3'b000;
  localparam logic [3:0] M_CACHE = 4'h0;
  localparam logic [1:0] M_LOCK = 2'b00;
  localparam int MEM_AW = 8;
endpackage : axup_pkg

// ---- hw/axup_slave.sv ----
// axi3 slave end: word memory behind write and read state machines
// Function
// - write address held until address ready
// - read address held until address ready
// - write data id equals write address id
// - response id equals write address id
// - read data id equals read address id
// - strobe bit n enables byte n
// - write last only on final beat
// - read last only on final beat
// - burst length sets exact beat count; write side ignores awlen and ends the burst on wlast
// - write beat addresses derived from size, type
// - read beat addresses derived from size, type
// - write response is one of four codes
// - read response is one of four codes
// - write valid with data, ready when able
// - response valid when present, ready when able
// - read valid with data, ready when able
// - master drives prot, cache, lock fields
// - size gives bytes per beat
// - accept only incrementing bursts, size 0-3
`timescale 1ns/1ps
module axup_slave
  import axup_pkg::*;
#(
  parameter int MEM_ADDR_W = MEM_AW
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  axup_if.slave bus,
  output logic O_WR_DONE,
  output logic O_RD_DONE,
  output logic [ID_W-1:0] O_LAST_ID
);
  typedef enum logic [1:0] {W_IDLE, W_DATA, W_RESP} axup_wst_type;
  typedef enum logic [1:0] {R_IDLE, R_DATA} axup_rst_type;

  // no reset on the array; a word never written reads as unknown
  logic [DATA_W-1:0] mem [0:(1<<MEM_ADDR_W)-1];
  axup_wst_type wst_q;
  axup_rst_type rst_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [2:0] wsize_q;
  logic [ID_W-1:0] wid_q;
  logic wbad_q;
  logic [ADDR_W-1:0] raddr_q;
  logic [2:0] rsize_q;
  logic [LEN_W-1:0] rcnt_q;
  logic [ID_W-1:0] rid_q;
  logic aw_ok;
  logic aw_fire;
  logic w_fire;
  logic ar_ok;
  logic ar_fire;
  logic r_fire;
  logic [MEM_ADDR_W-1:0] widx;
  logic [MEM_ADDR_W-1:0] ridx;

  // unsupported bursts are never accepted, so they stall the master
  assign aw_ok = bus.awvalid && (bus.awburst == BURST_INCR) && (bus.awsize <= SIZE_MAX);
  assign ar_ok = bus.arvalid && (bus.arburst == BURST_INCR) && (bus.arsize <= SIZE_MAX);
  assign aw_fire = aw_ok && bus.awready;
  assign w_fire = bus.wvalid && bus.wready;
  assign ar_fire = ar_ok && bus.arready;
  assign r_fire = bus.rvalid && bus.rready;
  // addresses beyond the array alias onto it
  assign widx = waddr_q[MEM_ADDR_W+1:2];
  assign ridx = raddr_q[MEM_ADDR_W+1:2];

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wst_q <= W_IDLE;
      bus.awready <= 1'b0;
      bus.wready <= 1'b0;
      bus.bvalid <= 1'b0;
      bus.bid <= '0;
      bus.bresp <= RESP_OKAY;
      waddr_q <= '0;
      wsize_q <= '0;
      wid_q <= '0;
      wbad_q <= 1'b0;
    end else begin
      unique case (wst_q)
        W_IDLE: begin
          // ready only answers a supported request, so valid with ready is always an acceptance
          bus.awready <= aw_ok && !bus.awready;
          if (aw_fire) begin
            bus.wready <= 1'b1;
            waddr_q <= bus.awaddr;
            wsize_q <= bus.awsize;
            wid_q <= bus.awid;
            wbad_q <= 1'b0;
            wst_q <= W_DATA;
          end
        end
        W_DATA: begin
          if (w_fire) begin
            waddr_q <= waddr_q + (ADDR_W'(1) << wsize_q);
            // one beat with a foreign id spoils the response of the whole burst
            if (bus.wid != wid_q) wbad_q <= 1'b1;
            if (bus.wlast) begin
              bus.wready <= 1'b0;
              bus.bvalid <= 1'b1;
              bus.bid <= wid_q;
              bus.bresp <= (wbad_q || bus.wid != wid_q) ? RESP_SLVERR : RESP_OKAY;
              wst_q <= W_RESP;
            end
          end
        end
        W_RESP: begin
          // response stands until the master takes it
          if (bus.bready) begin
            bus.bvalid <= 1'b0;
            wst_q <= W_IDLE;
          end
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (w_fire) begin
      for (int b = 0; b < STRB_W; b++) begin
        if (bus.wstrb[b]) mem[widx][8*b +: 8] <= bus.wdata[8*b +: 8];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rst_q <= R_IDLE;
      bus.arready <= 1'b0;
      bus.rvalid <= 1'b0;
      bus.rlast <= 1'b0;
      bus.rid <= '0;
      bus.rresp <= RESP_OKAY;
      raddr_q <= '0;
      rsize_q <= '0;
      rcnt_q <= '0;
      rid_q <= '0;
    end else begin
      unique case (rst_q)
        R_IDLE: begin
          // one-cycle ready pulse for a supported request; it drops on the accepting edge
          bus.arready <= ar_ok && !bus.arready;
          if (ar_fire) begin
            raddr_q <= bus.araddr;
            rsize_q <= bus.arsize;
            rcnt_q <= bus.arlen;
            rid_q <= bus.arid;
            rst_q <= R_DATA;
          end
        end
        R_DATA: begin
          // one idle cycle between beats keeps the memory read registered
          if (!bus.rvalid) begin
            bus.rvalid <= 1'b1;
            bus.rid <= rid_q;
            bus.rresp <= RESP_OKAY;
            bus.rlast <= (rcnt_q == '0);
          end else if (r_fire) begin
            bus.rvalid <= 1'b0;
            bus.rlast <= 1'b0;
            raddr_q <= raddr_q + (ADDR_W'(1) << rsize_q);
            rcnt_q <= rcnt_q - 1'b1;
            if (bus.rlast) rst_q <= R_IDLE;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end

  // data loads only while no beat stands, so it stays put until taken
  always_ff @(posedge I_CLK_SYS) begin
    if (rst_q == R_DATA && !bus.rvalid) bus.rdata <= mem[ridx];
  end

  // done pulses trail their handshakes by one cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_WR_DONE <= 1'b0;
    end else begin
      O_WR_DONE <= bus.bvalid && bus.bready;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_RD_DONE <= 1'b0;
    end else begin
      O_RD_DONE <= r_fire && bus.rlast;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_LAST_ID <= '0;
    end else if (bus.bvalid && bus.bready) begin
      O_LAST_ID <= bus.bid;
    end
  end
endmodule : axup_slave

// ---- verification/axup_properties.sv ----
// protocol checks on the link joining master end and slave end
`timescale 1ns/1ps
module axup_properties
  import axup_pkg::*;
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [ID_W-1:0] awid,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [LEN_W-1:0] awlen,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wlast,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [ID_W-1:0] bid,
  input wire logic bvalid,
  input wire logic [ID_W-1:0] arid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [LEN_W-1:0] arlen,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ID_W-1:0] rid,
  input wire logic rlast,
  input wire logic rvalid,
  input wire logic rready
);
  logic [ID_W-1:0] awid_q, arid_q;
  logic [LEN_W-1:0] awlen_q, arlen_q, wcnt_q, rcnt_q;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  always_ff @(posedge I_CLK_SYS) begin
    if (awvalid && awready) begin
      awid_q <= awid;
      awlen_q <= awlen;
    end
    if (arvalid && arready) begin
      arid_q <= arid;
      arlen_q <= arlen;
    end
  end
  // beat counters restart on the last beat, so a missing last fails on the beat that should have carried it
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || (wvalid && wready && wlast)) begin
      wcnt_q <= 4'h0;
    end else if (wvalid && wready) begin
      wcnt_q <= wcnt_q + 4'h1;
    end
  end
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || (rvalid && rready && rlast)) begin
      rcnt_q <= 4'h0;
    end else if (rvalid && rready) begin
      rcnt_q <= rcnt_q + 4'h1;
    end
  end
  a_aw_hold: assert property (awvalid && !awready |=> awvalid && $stable(awaddr) && $stable(awid))
    else $error("write address not held");
  a_ar_hold: assert property (arvalid && !arready |=> arvalid && $stable(araddr) && $stable(arlen))
    else $error("read address not held");
  a_bid_match: assert property (bvalid |-> bid == awid_q)
    else $error("response id differs from write id");
  a_rid_match: assert property (rvalid |-> rid == arid_q)
    else $error("read id differs from address id");
  a_wlast_pos: assert property (wvalid |-> wlast == (wcnt_q == awlen_q))
    else $error("write last misplaced");
  a_rlast_pos: assert property (rvalid |-> rlast == (rcnt_q == arlen_q))
    else $error("read last misplaced");
  a_resp_after_last: assert property ($rose(bvalid) |-> $past(wvalid && wready && wlast))
    else $error("response before last beat");
  a_reset_quiet: assert property ($past(I_RST) |-> !(awvalid || wvalid || bvalid || arvalid || rvalid))
    else $error("valid high right after reset");
  a_ready_gated: assert property ((awready |-> awvalid) and (arready |-> arvalid))
    else $error("address ready without a request");
endmodule : axup_properties

// ---- verification/tb.sv ----
// bench: user bursts through both ends, plus a hand-driven faulty master
`timescale 1ns/1ps
module tb;
  import axup_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr_req = 1'b0;
  logic rd_req = 1'b0;
  logic [ID_W-1:0] id = 4'h0;
  logic [ADDR_W-1:0] addr = 32'h0;
  logic [LEN_W-1:0] len = 4'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic [STRB_W-1:0] wstrb = 4'hf;
  logic [DATA_W-1:0] rdata;
  logic take, rvld, done, busy, wr_done, rd_done;
  logic [1:0] resp;
  logic [ID_W-1:0] last_id;
  logic [31:0] seed = 32'h2957; // 10583
  logic [31:0] mem [16];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  axup_if bus();
  axup_if bus2();
  axup_master i_axup_master (.I_CLK_SYS(clk), .I_RST(rst), .bus(bus), .I_WR_REQ(wr_req), .I_RD_REQ(rd_req),
    .I_ID(id), .I_ADDR(addr), .I_LEN(len), .I_WDATA(wdata), .I_WSTRB(wstrb), .O_BUSY(busy), .O_WDATA_TAKE(take),
    .O_RDATA_VALID(rvld), .O_RDATA(rdata), .O_DONE(done), .O_RESP(resp));
  axup_slave i_axup_slave (.I_CLK_SYS(clk), .I_RST(rst), .bus(bus), .O_WR_DONE(wr_done), .O_RD_DONE(rd_done),
    .O_LAST_ID(last_id));
  axup_slave i_axup_slave_b (.I_CLK_SYS(clk), .I_RST(rst), .bus(bus2), .O_WR_DONE(), .O_RD_DONE(),
    .O_LAST_ID());
  axup_properties i_axup_properties (.I_CLK_SYS(clk), .I_RST(rst), .awid(bus.awid), .awaddr(bus.awaddr),
    .awlen(bus.awlen), .awvalid(bus.awvalid), .awready(bus.awready), .wlast(bus.wlast), .wvalid(bus.wvalid),
    .wready(bus.wready), .bid(bus.bid), .bvalid(bus.bvalid), .arid(bus.arid), .araddr(bus.araddr),
    .arlen(bus.arlen), .arvalid(bus.arvalid), .arready(bus.arready), .rid(bus.rid), .rlast(bus.rlast),
    .rvalid(bus.rvalid), .rready(bus.rready));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  // word w is the start; strobe mask m forces lanes on so the model never holds unknown bytes
  task automatic wr_burst(input logic [3:0] i, input int w, input logic [3:0] l, input logic [3:0] m);
    int k;
    k = 0;
    @(posedge clk);
    id <= i;
    addr <= 32'(w * 4);
    len <= l;
    wdata <= rnd();
    wstrb <= 4'(rnd()) | m;
    wr_req <= 1'b1;
    @(posedge clk);
    wr_req <= 1'b0;
    @(negedge clk);
    check(32'(busy), 32'h1);
    while (!done) begin
      @(negedge clk);
      if (take) begin
        for (int b = 0; b < 4; b++) if (wstrb[b]) mem[w + k][8*b +: 8] = wdata[8*b +: 8];
        k++;
        wdata = rnd();
        wstrb = 4'(rnd()) | m;
      end
    end
    check(32'(resp), 32'(RESP_OKAY));
    check(32'({busy, wr_done}), 32'h1);
    @(negedge clk);
    check(32'(last_id), 32'(i));
  endtask : wr_burst
  task automatic rd_burst(input logic [3:0] i, input int w, input logic [3:0] l);
    int k;
    k = 0;
    @(posedge clk);
    id <= i;
    addr <= 32'(w * 4);
    len <= l;
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    @(negedge clk);
    check(32'(busy), 32'h1);
    while (!done) begin
      @(negedge clk);
      if (rvld) begin
        check(rdata, mem[w + k]);
        k++;
      end
    end
    check(32'(k), 32'(l) + 32'h1);
    check(32'(resp), 32'(RESP_OKAY));
    check(32'({busy, rd_done}), 32'h1);
  endtask : rd_burst
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  initial begin
    {bus2.awid, bus2.awaddr, bus2.awlen, bus2.awsize, bus2.awburst, bus2.awlock, bus2.awcache, bus2.awprot,
      bus2.awvalid, bus2.wid, bus2.wdata, bus2.wlast, bus2.wvalid, bus2.bready, bus2.arid, bus2.araddr,
      bus2.arlen, bus2.arsize, bus2.arburst, bus2.arlock, bus2.arcache, bus2.arprot, bus2.arvalid,
      bus2.rready} = '0;
    bus2.wstrb = 4'hf;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr_burst(4'h3, 0, 4'hf, 4'hf);
    check(32'({bus.awprot, bus.awcache, bus.awlock}), 32'({M_PROT, M_CACHE, M_LOCK}));
    check(32'({bus.arprot, bus.arcache, bus.arlock}), 32'({M_PROT, M_CACHE, M_LOCK}));
    rd_burst(4'hc, 0, 4'hf);
    for (int t = 0; t < 8; t++) begin
      len = 4'(rnd() % 8);
      wr_burst(4'(t), t, len, 4'h0);
      rd_burst(4'(t + 8), t, len);
    end
    // fixed burst type must stall: no address accepted, no data taken, no response
    @(posedge clk);
    bus2.awid <= 4'h5;
    bus2.awsize <= 3'h2;
    bus2.awvalid <= 1'b1;
    bus2.wid <= 4'h6;
    bus2.wlast <= 1'b1;
    bus2.wvalid <= 1'b1;
    repeat (10) begin
      @(negedge clk);
      check(32'(bus2.awready || bus2.wready || bus2.bvalid), 32'h0);
    end
    @(posedge clk);
    bus2.awburst <= BURST_INCR;
    do @(negedge clk); while (!bus2.awready);
    @(posedge clk);
    bus2.awvalid <= 1'b0;
    do @(negedge clk); while (!bus2.wready);
    @(posedge clk);
    bus2.wvalid <= 1'b0;
    bus2.bready <= 1'b1;
    do @(negedge clk); while (!bus2.bvalid);
    check(32'(bus2.bresp), 32'(RESP_SLVERR));
    check(32'(bus2.bid), 32'h5);
    @(posedge clk);
    bus2.bready <= 1'b0;
    finish_test();
  end
endmodule : tb
